// >>> design/amct_pkg.sv
package amct_pkg;

    // =====================================================================
    // addressing modes covered by the timing table
    typedef enum logic [4:0] {
        AMCT_ABS = 5'h00,
        AMCT_ABS_IDX_IND = 5'h01,
        AMCT_ABS_IND = 5'h02,
        AMCT_ABS_LONG = 5'h03,
        AMCT_ABS_LONG_X = 5'h04,
        AMCT_ABS_X = 5'h05,
        AMCT_ABS_Y = 5'h06,
        AMCT_ACC = 5'h07,
        AMCT_BLOCK_MOVE = 5'h08,
        AMCT_DIR = 5'h09,
        AMCT_DIR_IDX_IND = 5'h0A,
        AMCT_DIR_IND = 5'h0B,
        AMCT_DIR_IND_IDX = 5'h0C,
        AMCT_DIR_IND_LONG_IDX = 5'h0D,
        AMCT_DIR_IND_LONG = 5'h0E,
        AMCT_DIR_X = 5'h0F,
        AMCT_DIR_Y = 5'h10,
        AMCT_IMM = 5'h11,
        AMCT_IMPL = 5'h12,
        AMCT_REL = 5'h13,
        AMCT_REL_LONG = 5'h14,
        AMCT_STACK = 5'h15,
        AMCT_STK_REL = 5'h16,
        AMCT_STK_REL_IND_IDX = 5'h17
    } amct_mode_t;

    // =====================================================================
    // request: one instruction to be timed
    typedef struct packed {
        amct_mode_t mode;
        logic [7:0] operand_byte;
        logic [15:0] stack_ptr;
        logic [15:0] y_index;
        logic [7:0] data_bank_base;
        logic [7:0] direct_low_byte;
        logic acc_width_8;
        logic idx_width_8;
        logic uses_index_width;
        logic page_crossed;
        logic branch_taken;
        logic rmw;
        logic [3:0] stack_cycles;
        logic [2:0] stack_bytes;
    } amct_req_t;

    // answer
    typedef struct packed {
        logic [3:0] cycles;
        logic [2:0] bytes;
        logic [15:0] ptr_addr;
        logic [23:0] eff_addr;
    } amct_rsp_t;

    // =====================================================================
    // extra-cycle figures
    localparam logic [3:0] AMCT_ADD_PAGE = 4'h1;
    localparam logic [3:0] AMCT_ADD_BRANCH = 4'h1;
    localparam logic [3:0] AMCT_ADD_WIDE = 4'h1;
    localparam logic [2:0] AMCT_ADD_IMM_BYTE = 3'h1;
    localparam logic [3:0] AMCT_ADD_DL = 4'h1;
    localparam logic [3:0] AMCT_ADD_RMW_8 = 4'h2;
    localparam logic [3:0] AMCT_ADD_RMW_16 = 4'h3;
    localparam logic [7:0] AMCT_DL_ALIGNED = 8'h00;
    localparam logic [7:0] AMCT_BANK_ZERO = 8'h00;
    localparam logic [3:0] AMCT_ONE_CYCLE = 4'h1;
    localparam logic [3:0] AMCT_NO_CYCLE = 4'h0;
    localparam logic [2:0] AMCT_NO_BYTE = 3'h0;

    // base cycles and lengths of the modes that the checks single out
    localparam logic [3:0] AMCT_CYC_SRII = 4'h7;
    localparam logic [3:0] AMCT_CYC_JMP_IDX_IND = 4'h6;
    localparam logic [3:0] AMCT_CYC_DIR_IND_LONG_IDX = 4'h6;
    localparam logic [3:0] AMCT_CYC_DIR_IDX_IND = 4'h6;
    localparam logic [3:0] AMCT_CYC_DIR_IND_IDX = 4'h5;
    localparam logic [3:0] AMCT_CYC_ABS_X = 4'h4;
    localparam logic [3:0] AMCT_CYC_ABS_Y = 4'h4;
    localparam logic [3:0] AMCT_CYC_DIR = 4'h3;
    localparam logic [3:0] AMCT_CYC_REL = 4'h2;
    localparam logic [3:0] AMCT_CYC_IMM = 4'h2;
    localparam logic [2:0] AMCT_LEN_TWO = 3'h2;
    localparam logic [2:0] AMCT_LEN_THREE = 3'h3;

endpackage : amct_pkg

// >>> design/amct_timing.sv
// What this block does
// - stack-relative indirect pointer is offset byte plus stack pointer, bank zero
// - upper eight base-address bits come from the data bank base
// - operand address is full 24-bit base plus Y index
// - stack-relative offset byte is unsigned 0 to 255, never sign-extended
// - stack relative indirect indexed takes 7 cycles, 2 bytes, plus width
// - absolute indexed indirect jump takes 6 cycles and 3 bytes
// - long indirect indexed Y direct takes 6 cycles, 2 bytes, adjusted
// - direct indexed indirect X takes 6 cycles, 2 bytes, adjusted
// - page crossing adds one cycle where the mode allows it
// - taken relative branch adds one cycle
// - 16-bit width adds one cycle; immediate grows one byte
// - direct modes add one cycle when direct low byte is nonzero
// - read-modify-write adds 2 cycles 8-bit, 3 cycles 16-bit
`timescale 1ns/1ps
`default_nettype none

module amct_timing (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire amct_pkg::amct_req_t req,
    output logic rsp_valid,
    output amct_pkg::amct_rsp_t rsp
);
    import amct_pkg::*;

    // =====================================================================
    // checks below all run on the one clock and rest during reset
    default clocking amct_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // =====================================================================
    // helpers for the checks; amct_is_wide also feeds the timing logic
    // 16-bit work when the accumulator, or an index the mode uses, is wide
    function automatic logic amct_is_wide(input amct_req_t r);
        return ~r.acc_width_8 | (r.uses_index_width & ~r.idx_width_8);
    endfunction : amct_is_wide

    // one extra cycle when the condition holds
    function automatic logic [3:0] amct_add_if(input logic b);
        return b ? AMCT_ONE_CYCLE : AMCT_NO_CYCLE;
    endfunction : amct_add_if

    // read-modify-write cost depends on the accumulator width only
    function automatic logic [3:0] amct_rmw_add(input amct_req_t r);
        logic [3:0] add;
        add = AMCT_NO_CYCLE;
        if (r.rmw) begin
            add = r.acc_width_8 ? AMCT_ADD_RMW_8 : AMCT_ADD_RMW_16;
        end
        return add;
    endfunction : amct_rmw_add

    // =====================================================================
    // per-mode table: base cycles, bytes, which notes apply
    typedef struct packed {
        logic [3:0] base_cyc;
        logic [2:0] base_len;
        logic pg;
        logic br;
        logic wide;
        logic dl;
        logic rmw_ok;
    } amct_entry_t;

    function automatic amct_entry_t amct_lookup(input amct_mode_t m);
        amct_entry_t e;
        e = '0;
        case (m)
            AMCT_ABS: e = '{4'h4, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
            AMCT_ABS_IDX_IND: e = '{4'h6, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0,
                1'b0};
            AMCT_ABS_IND: e = '{4'h5, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            AMCT_ABS_LONG: e = '{4'h5, 3'h4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            AMCT_ABS_LONG_X: e = '{4'h5, 3'h4, 1'b0, 1'b0, 1'b1, 1'b0,
                1'b0};
            AMCT_ABS_X: e = '{4'h4, 3'h3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
            AMCT_ABS_Y: e = '{4'h4, 3'h3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            AMCT_ACC: e = '{4'h2, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            AMCT_BLOCK_MOVE: e = '{4'h7, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0,
                1'b0};
            AMCT_DIR: e = '{4'h3, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            AMCT_DIR_IDX_IND: e = '{4'h6, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1,
                1'b0};
            AMCT_DIR_IND: e = '{4'h5, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            AMCT_DIR_IND_IDX: e = '{4'h5, 3'h2, 1'b1, 1'b0, 1'b1, 1'b1,
                1'b0};
            AMCT_DIR_IND_LONG_IDX: e = '{4'h6, 3'h2, 1'b0, 1'b0, 1'b1,
                1'b1, 1'b0};
            AMCT_DIR_IND_LONG: e = '{4'h6, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1,
                1'b0};
            AMCT_DIR_X: e = '{4'h4, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            AMCT_DIR_Y: e = '{4'h4, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            AMCT_IMM: e = '{4'h2, 3'h2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            AMCT_IMPL: e = '{4'h2, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            AMCT_REL: e = '{4'h2, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            AMCT_REL_LONG: e = '{4'h3, 3'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            AMCT_STK_REL: e = '{4'h4, 3'h2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            AMCT_STK_REL_IND_IDX: e = '{4'h7, 3'h2, 1'b0, 1'b0, 1'b1, 1'b0,
                1'b0};
            default: e = '0;
        endcase
        return e;
    endfunction : amct_lookup

    // =====================================================================
    // timing and length
    amct_entry_t ent;
    logic is_wide;
    logic [3:0] nxt_cycles;
    logic [2:0] nxt_bytes;
    logic [15:0] nxt_ptr;
    logic [23:0] nxt_eff;
    logic [23:0] base_addr;

    always_comb begin
        ent = amct_lookup(req.mode);
        is_wide = amct_is_wide(req);
        nxt_cycles = ent.base_cyc;
        nxt_bytes = ent.base_len;
        if (req.mode == AMCT_STACK) begin
            nxt_cycles = req.stack_cycles;
            nxt_bytes = req.stack_bytes;
        end
        if (ent.pg && req.page_crossed) begin
            nxt_cycles = nxt_cycles + AMCT_ADD_PAGE;
        end
        if (ent.br && req.branch_taken) begin
            nxt_cycles = nxt_cycles + AMCT_ADD_BRANCH;
        end
        if (ent.wide && is_wide) begin
            nxt_cycles = nxt_cycles + AMCT_ADD_WIDE;
            if (req.mode == AMCT_IMM) begin
                nxt_bytes = nxt_bytes + AMCT_ADD_IMM_BYTE;
            end
        end
        if (ent.dl && req.direct_low_byte != AMCT_DL_ALIGNED) begin
            nxt_cycles = nxt_cycles + AMCT_ADD_DL;
        end
        if (ent.rmw_ok && req.rmw) begin
            nxt_cycles = nxt_cycles + (req.acc_width_8 ? AMCT_ADD_RMW_8
                : AMCT_ADD_RMW_16);
        end
    end

    // =====================================================================
    // stack relative indirect indexed address
    always_comb begin
        nxt_ptr = req.stack_ptr + {8'h00, req.operand_byte};
        base_addr = {req.data_bank_base, 16'h0000};
        nxt_eff = base_addr + {8'h00, req.y_index};
    end

    // =====================================================================
    // answer registers
    logic rsp_valid_ff;
    amct_rsp_t rsp_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= req_valid;
        end
    end

    // the answer holds until the next request is taken
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rsp_ff <= '0;
        end else if (req_valid) begin
            rsp_ff.cycles <= nxt_cycles;
            rsp_ff.bytes <= nxt_bytes;
            rsp_ff.ptr_addr <= nxt_ptr;
            rsp_ff.eff_addr <= nxt_eff;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp = rsp_ff;

    // =====================================================================
    // checks: each answer against the request taken one edge earlier
    amct_req_t took_ff;
    logic took_valid_ff;
    logic took_wide;
    logic took_dl;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            took_valid_ff <= 1'b0;
        end else begin
            took_valid_ff <= req_valid;
        end
    end

    always_ff @(posedge ref_clk) begin
        took_ff <= req;
    end

    always_comb begin
        took_wide = amct_is_wide(took_ff);
        took_dl = took_ff.direct_low_byte != AMCT_DL_ALIGNED;
    end

    // =====================================================================
    // addresses
    a_ptr_unsigned: assert property (
        took_valid_ff
        |-> rsp.ptr_addr == took_ff.stack_ptr + 16'(took_ff.operand_byte))
    else $error("stack pointer offset not taken as unsigned");

    a_eff_bank_y: assert property (
        took_valid_ff
        |-> rsp.eff_addr == {took_ff.data_bank_base, 16'h0000}
            + 24'(took_ff.y_index))
    else $error("effective address not bank base plus Y");

    // =====================================================================
    // cycle counts and lengths per mode
    a_srii_timing: assert property (
        took_valid_ff && took_ff.mode == AMCT_STK_REL_IND_IDX
        |-> rsp.cycles == AMCT_CYC_SRII + amct_add_if(took_wide)
            && rsp.bytes == AMCT_LEN_TWO)
    else $error("stack relative indirect indexed timing wrong");

    a_jmp_timing: assert property (
        took_valid_ff && took_ff.mode == AMCT_ABS_IDX_IND
        |-> rsp.cycles == AMCT_CYC_JMP_IDX_IND
            && rsp.bytes == AMCT_LEN_THREE)
    else $error("indexed indirect jump timing wrong");

    a_long_ind_timing: assert property (
        took_valid_ff && took_ff.mode == AMCT_DIR_IND_LONG_IDX
        |-> rsp.cycles == AMCT_CYC_DIR_IND_LONG_IDX + amct_add_if(took_wide)
            + amct_add_if(took_dl) && rsp.bytes == AMCT_LEN_TWO)
    else $error("long indirect indexed timing wrong");

    a_idx_ind_timing: assert property (
        took_valid_ff && took_ff.mode == AMCT_DIR_IDX_IND
        |-> rsp.cycles == AMCT_CYC_DIR_IDX_IND + amct_add_if(took_wide)
            + amct_add_if(took_dl) && rsp.bytes == AMCT_LEN_TWO)
    else $error("direct indexed indirect timing wrong");

    a_page_extra: assert property (
        took_valid_ff && took_ff.mode == AMCT_ABS_Y
        |-> rsp.cycles == AMCT_CYC_ABS_Y + amct_add_if(took_ff.page_crossed)
            + amct_add_if(took_wide))
    else $error("page crossing cycle wrong");

    a_page_ind_idx: assert property (
        took_valid_ff && took_ff.mode == AMCT_DIR_IND_IDX
        |-> rsp.cycles == AMCT_CYC_DIR_IND_IDX
            + amct_add_if(took_ff.page_crossed) + amct_add_if(took_wide)
            + amct_add_if(took_dl))
    else $error("indirect indexed page cycle wrong");

    a_branch_extra: assert property (
        took_valid_ff && took_ff.mode == AMCT_REL
        |-> rsp.cycles == AMCT_CYC_REL + amct_add_if(took_ff.branch_taken)
            && rsp.bytes == AMCT_LEN_TWO)
    else $error("taken branch cycle wrong");

    a_imm_length: assert property (
        took_valid_ff && took_ff.mode == AMCT_IMM
        |-> rsp.cycles == AMCT_CYC_IMM + amct_add_if(took_wide)
            && rsp.bytes == AMCT_LEN_TWO
                + (took_wide ? AMCT_ADD_IMM_BYTE : AMCT_NO_BYTE))
    else $error("immediate width adjustment wrong");

    a_rmw_abs_x: assert property (
        took_valid_ff && took_ff.mode == AMCT_ABS_X
        |-> rsp.cycles == AMCT_CYC_ABS_X + amct_add_if(took_ff.page_crossed)
            + amct_add_if(took_wide) + amct_rmw_add(took_ff))
    else $error("indexed read-modify-write cycles wrong");

    a_rmw_direct: assert property (
        took_valid_ff && took_ff.mode == AMCT_DIR
        |-> rsp.cycles == AMCT_CYC_DIR + amct_add_if(took_wide)
            + amct_add_if(took_dl) + amct_rmw_add(took_ff))
    else $error("direct read-modify-write cycles wrong");

    // =====================================================================
    // main scenarios
    c_srii_wide: cover property (
        took_valid_ff && took_ff.mode == AMCT_STK_REL_IND_IDX && took_wide);

    c_rmw_wide: cover property (
        took_valid_ff && took_ff.mode == AMCT_ABS_X && took_ff.rmw
        && took_wide);

    c_branch_taken: cover property (
        took_valid_ff && took_ff.mode == AMCT_REL && took_ff.branch_taken);

    c_dl_unaligned: cover property (
        took_valid_ff && took_ff.mode == AMCT_DIR_IDX_IND && took_dl);

endmodule : amct_timing

`default_nettype wire

// >>> tb/amct_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

module amct_fetch_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic fetch_go,
    input wire amct_pkg::amct_req_t fetch_req,
    output logic req_valid,
    output var amct_pkg::amct_req_t req
);
    import amct_pkg::*;

    // =========================================================
    // instruction bytes reach the core one bus cycle after fetch
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_valid <= 1'b0;
        end else begin
            req_valid <= fetch_go;
        end
    end

    always_ff @(posedge ref_clk) begin
        req <= fetch_req;
    end
endmodule : amct_fetch_model

`default_nettype wire

// >>> tb/amct_timing_test.sv
`timescale 1ns/1ps
`default_nettype none

module amct_timing_test;
    import amct_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic fetch_go = 1'b0;
    amct_req_t fetch_req = '0;
    logic req_valid;
    amct_req_t req;
    logic rsp_valid;
    amct_rsp_t rsp;
    int miscompares = 0;
    int n_compared = 0;

    always #2.5 ref_clk = ~ref_clk;

    amct_fetch_model mem_u (.ref_clk(ref_clk), .srst(srst),
        .fetch_go(fetch_go), .fetch_req(fetch_req),
        .req_valid(req_valid), .req(req));
    amct_timing dut_u (.ref_clk(ref_clk), .srst(srst),
        .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp));

    // =========================================================
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic run(input amct_req_t r, input logic [3:0] cyc,
                       input logic [2:0] byt);
        int i;
        @(posedge ref_clk);
        fetch_go <= 1'b1;
        fetch_req <= r;
        @(posedge ref_clk);
        fetch_go <= 1'b0;
        for (i = 0; i < 5 && rsp_valid !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (rsp_valid !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        chk(rsp.cycles, cyc);
        chk(rsp.bytes, byt);
    endtask : run

    function automatic amct_req_t mk(input amct_mode_t m);
        amct_req_t r;
        r = '0;
        r.mode = m;
        r.acc_width_8 = 1'b1;
        r.idx_width_8 = 1'b1;
        return r;
    endfunction : mk

    // =========================================================
    task automatic t_stack_rel_ind;
        amct_req_t r;
        r = mk(AMCT_STK_REL_IND_IDX);
        r.operand_byte = 8'hF0;
        r.stack_ptr = 16'h01FF;
        r.y_index = 16'hFFFF;
        r.data_bank_base = 8'h12;
        run(r, 4'h7, 3'h2);
        chk(rsp.ptr_addr, 24'h0002EF);
        chk(rsp.eff_addr, 24'h12FFFF);
        r.acc_width_8 = 1'b0;
        run(r, 4'h8, 3'h2);
    endtask : t_stack_rel_ind

    task automatic t_direct;
        amct_req_t r;
        run(mk(AMCT_ABS_IDX_IND), 4'h6, 3'h3);
        run(mk(AMCT_DIR_IND_LONG_IDX), 4'h6, 3'h2);
        r = mk(AMCT_DIR_IND_LONG_IDX);
        r.direct_low_byte = 8'h01;
        r.acc_width_8 = 1'b0;
        run(r, 4'h8, 3'h2);
        r = mk(AMCT_DIR_IDX_IND);
        run(r, 4'h6, 3'h2);
        r.direct_low_byte = 8'h80;
        run(r, 4'h7, 3'h2);
    endtask : t_direct

    task automatic t_extras;
        amct_req_t r;
        r = mk(AMCT_ABS_X);
        r.page_crossed = 1'b1;
        r.rmw = 1'b1;
        run(r, 4'h7, 3'h3);
        r.acc_width_8 = 1'b0;
        run(r, 4'h9, 3'h3);
        r = mk(AMCT_ABS_Y);
        r.page_crossed = 1'b1;
        run(r, 4'h5, 3'h3);
        r = mk(AMCT_REL);
        r.branch_taken = 1'b1;
        run(r, 4'h3, 3'h2);
        r.branch_taken = 1'b0;
        run(r, 4'h2, 3'h2);
        r = mk(AMCT_IMM);
        r.uses_index_width = 1'b1;
        r.idx_width_8 = 1'b0;
        run(r, 4'h3, 3'h3);
        r = mk(AMCT_DIR_IND_IDX);
        r.page_crossed = 1'b1;
        run(r, 4'h6, 3'h2);
        r = mk(AMCT_DIR);
        r.rmw = 1'b1;
        r.direct_low_byte = 8'h01;
        run(r, 4'h6, 3'h2);
        r.acc_width_8 = 1'b0;
        run(r, 4'h8, 3'h2);
        r = mk(AMCT_STACK);
        r.stack_cycles = 4'h8;
        r.stack_bytes = 3'h4;
        r.acc_width_8 = 1'b0;
        run(r, 4'h8, 3'h4);
    endtask : t_extras

    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        t_stack_rel_ind();
        t_direct();
        t_extras();
        wrap_up();
    end
endmodule : amct_timing_test

`default_nettype wire
